// File: core/ist_pkg.sv
// Constants, types and states shared by the I2C slave data and time-out block.
package ist_pkg;
	localparam int BYTE_BITS = 8;
	localparam logic [3:0] BIT_LAST = 4'h8;
	localparam int SUB_DIV_W = 5;
	localparam logic [4:0] SUB_DIV_LAST = 5'h1f;
	localparam int TO_CNT_W = 7;
	localparam int TO_SEL_W = 6;
	localparam int EN_BIT = 7;
	localparam int FLAG_BIT = 6;
	localparam logic [2:0] PIN_RST = 3'h3;
	localparam int PIN_SCL = 0;
	localparam int PIN_SDA = 1;
	localparam int PIN_SUB = 2;

	typedef struct packed {
		logic en;
		logic flag;
		logic [TO_SEL_W-1:0] sel;
	} ist_toc_type;

	typedef struct packed {
		logic bus_busy;
		logic addr_match;
		logic tx_mode;
		logic read_req;
		logic tx_ack_bit;
		logic rx_ack_bit;
	} ist_ctrl1_type;

	localparam ist_toc_type TOC_POR = '{en: 1'b0, flag: 1'b0, sel: 6'h00};
	localparam ist_ctrl1_type CTRL1_POR = '{bus_busy: 1'b0,
		addr_match: 1'b0, tx_mode: 1'b0, read_req: 1'b0,
		tx_ack_bit: 1'b0, rx_ack_bit: 1'b1};

	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_ADDR = 6'h02,
		ST_ADDR_ACK = 6'h04,
		ST_DATA = 6'h08,
		ST_DATA_ACK = 6'h10,
		ST_WAIT_STOP = 6'h20
	} ist_state_type;
endpackage

// File: core/ist_i2c_slave.sv
// I2C slave data phase, acknowledge, clock stretching and bus time-out.
`timescale 1ns/1ps
module ist_i2c_slave (
	input wire logic sys_clk, // System clock, 50 MHz.
	input wire logic rst_n, // Asynchronous reset, active low.
	input wire logic scl_in, // Clock line level.
	output logic scl_out, // Clock line drive value, always low.
	output logic scl_oe, // High while the clock line is held low.
	input wire logic sda_in, // Data line level.
	output logic sda_out, // Data line drive value, always low.
	output logic sda_oe, // High while the data line is pulled low.
	input wire logic sub_clock, // Free running low speed clock.
	input wire logic i2c_enable, // Interface enable from control reg 0.
	input wire logic [6:0] own_address_reg, // Own 7-bit slave address.
	input wire logic ctrl1_wr, // Strobe: load mode and acknowledge bits.
	input wire logic ctrl1_tx_mode, // Transmit mode value to load.
	input wire logic ctrl1_tx_ack, // Acknowledge level value to load.
	output ist_pkg::ist_ctrl1_type serial_ctrl_reg1, // Control reg 1.
	input wire logic data_wr, // Strobe: software writes data register.
	input wire logic [7:0] data_wdata, // Data written by software.
	input wire logic data_rd, // Strobe: software reads data register.
	output logic [7:0] serial_data_reg, // Shared serial data register.
	input wire logic toc_wr, // Strobe: write enable and select.
	input wire ist_pkg::ist_toc_type toc_wdata, // Time-out write value.
	input wire logic timeout_flag_clr, // Strobe: clear time-out flag.
	output ist_pkg::ist_toc_type timeout_ctrl_reg, // Time-out control.
	input wire logic irq_clr, // Strobe: clear interrupt flag.
	output logic serial_irq_flag // Sticky serial interrupt request.
);
	import ist_pkg::*;

	logic [2:0] pin_raw, s0_ff, s1_ff, s2_ff, filt_ff, prev_ff;
	ist_state_type st_ff;
	logic [3:0] bit_ff;
	logic [7:0] shift_ff;
	logic sda_oe_ff;
	logic stretch_ff;
	logic line_out_ff;
	ist_ctrl1_type ctrl1_ff;
	logic [7:0] data_ff;
	logic irq_ff;
	ist_toc_type toc_ff;
	logic to_run_ff;
	logic [SUB_DIV_W-1:0] pre_ff;
	logic [TO_CNT_W-1:0] to_cnt_ff;

	assign pin_raw = {sub_clock, sda_in, scl_in};

	// Three-stage synchronisers; a level counts once stages two and three agree.
	genvar g;
	for (g = 0; g < 3; g++) begin : g_sync
		always_ff @(posedge sys_clk or negedge rst_n) begin
			if (!rst_n) begin
				s0_ff[g] <= PIN_RST[g];
				s1_ff[g] <= PIN_RST[g];
				s2_ff[g] <= PIN_RST[g];
				filt_ff[g] <= PIN_RST[g];
				prev_ff[g] <= PIN_RST[g];
			end else begin
				s0_ff[g] <= pin_raw[g];
				s1_ff[g] <= s0_ff[g];
				s2_ff[g] <= s1_ff[g];
				if (s1_ff[g] == s2_ff[g]) begin
					filt_ff[g] <= s2_ff[g];
				end
				prev_ff[g] <= filt_ff[g];
			end
		end
	end

	logic scl, sda, scl_rise, scl_fall, sub_rise, start_det, stop_det;
	logic addr_done, addr_hit, byte_end, ack_end, tick, to_hit, htx;

	assign scl = filt_ff[PIN_SCL];
	assign sda = filt_ff[PIN_SDA];
	assign scl_rise = scl && !prev_ff[PIN_SCL];
	assign scl_fall = !scl && prev_ff[PIN_SCL];
	assign sub_rise = filt_ff[PIN_SUB] && !prev_ff[PIN_SUB];
	assign start_det = scl && prev_ff[PIN_SCL] && prev_ff[PIN_SDA] && !sda;
	assign stop_det = scl && prev_ff[PIN_SCL] && !prev_ff[PIN_SDA] && sda;
	assign htx = ctrl1_ff.tx_mode;
	assign addr_done = (st_ff == ST_ADDR) && scl_fall && (bit_ff == BIT_LAST);
	assign addr_hit = addr_done && (shift_ff[7:1] == own_address_reg);
	assign byte_end = (st_ff == ST_DATA) && !stretch_ff && scl_fall &&
		(bit_ff == BIT_LAST);
	assign ack_end = (st_ff == ST_DATA_ACK) && scl_fall;
	assign tick = sub_rise && (pre_ff == SUB_DIV_LAST);
	assign to_hit = to_run_ff && toc_ff.en && tick &&
		(to_cnt_ff == {1'b0, toc_ff.sel});

	// Bus protocol sequencer, data shifting and line drive.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_ff <= ST_IDLE;
			bit_ff <= 4'h0;
			shift_ff <= 8'h00;
			sda_oe_ff <= 1'b0;
			stretch_ff <= 1'b0;
		end else if (to_hit || stop_det || !i2c_enable) begin
			st_ff <= ST_IDLE;
			bit_ff <= 4'h0;
			sda_oe_ff <= 1'b0;
			stretch_ff <= 1'b0;
		end else if (start_det) begin
			st_ff <= ST_ADDR;
			bit_ff <= 4'h0;
			sda_oe_ff <= 1'b0;
			stretch_ff <= 1'b0;
		end else begin
			case (st_ff)
			ST_ADDR: begin
				if (scl_rise) begin
					shift_ff <= {shift_ff[6:0], sda};
					bit_ff <= bit_ff + 4'h1;
				end
				if (addr_done) begin
					st_ff <= addr_hit ? ST_ADDR_ACK : ST_WAIT_STOP;
					sda_oe_ff <= addr_hit;
				end
			end
			ST_ADDR_ACK: begin
				if (scl_fall) begin
					sda_oe_ff <= 1'b0;
					stretch_ff <= 1'b1;
					bit_ff <= 4'h0;
					st_ff <= ST_DATA;
				end
			end
			ST_DATA: begin
				if (stretch_ff) begin
					if (data_wr && htx) begin
						stretch_ff <= 1'b0;
						shift_ff <= data_wdata;
						sda_oe_ff <= !data_wdata[7];
					end else if (data_rd && !htx) begin
						stretch_ff <= 1'b0;
					end
				end else begin
					if (scl_rise) begin
						bit_ff <= bit_ff + 4'h1;
						if (!htx) begin
							shift_ff <= {shift_ff[6:0], sda};
						end
					end
					if (byte_end) begin
						st_ff <= ST_DATA_ACK;
						sda_oe_ff <= !htx && !ctrl1_ff.tx_ack_bit;
					end else if (scl_fall && htx) begin
						shift_ff <= {shift_ff[6:0], 1'b0};
						sda_oe_ff <= !shift_ff[6];
					end
				end
			end
			ST_DATA_ACK: begin
				if (scl_fall) begin
					sda_oe_ff <= 1'b0;
					bit_ff <= 4'h0;
					if (htx && ctrl1_ff.rx_ack_bit) begin
						st_ff <= ST_WAIT_STOP;
					end else begin
						stretch_ff <= 1'b1;
						st_ff <= ST_DATA;
					end
				end
			end
			ST_IDLE, ST_WAIT_STOP: begin
				sda_oe_ff <= 1'b0;
			end
			default: begin
				st_ff <= ST_IDLE;
			end
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl1_ff <= CTRL1_POR;
		end else if (to_hit) begin
			ctrl1_ff <= CTRL1_POR;
		end else begin
			if (ctrl1_wr) begin
				ctrl1_ff.tx_mode <= ctrl1_tx_mode;
				ctrl1_ff.tx_ack_bit <= ctrl1_tx_ack;
			end
			if (start_det) begin
				ctrl1_ff.bus_busy <= 1'b1;
				ctrl1_ff.addr_match <= 1'b0;
			end else if (stop_det) begin
				ctrl1_ff.bus_busy <= 1'b0;
			end
			if (addr_hit && i2c_enable) begin
				ctrl1_ff.addr_match <= 1'b1;
				ctrl1_ff.read_req <= shift_ff[0];
			end else if (byte_end) begin
				ctrl1_ff.addr_match <= 1'b0;
			end
			if ((st_ff == ST_DATA_ACK) && htx && scl_rise) begin
				ctrl1_ff.rx_ack_bit <= sda;
			end
		end
	end

	// Data register keeps its contents across a time-out.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			data_ff <= 8'h00;
		end else if (byte_end && !htx) begin
			data_ff <= shift_ff;
		end else if (data_wr) begin
			data_ff <= data_wdata;
		end
	end

	// A new event in the clearing cycle keeps the flag set.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_ff <= 1'b0;
		end else if (to_hit || ack_end || (addr_hit && i2c_enable)) begin
			irq_ff <= 1'b1;
		end else if (irq_clr) begin
			irq_ff <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			toc_ff <= TOC_POR;
		end else begin
			if (to_hit) begin
				toc_ff.en <= 1'b0;
			end else if (toc_wr) begin
				toc_ff.en <= toc_wdata.en;
			end
			if (toc_wr) begin
				toc_ff.sel <= toc_wdata.sel;
			end
			if (to_hit) begin
				toc_ff.flag <= 1'b1;
			end else if (timeout_flag_clr) begin
				toc_ff.flag <= 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			to_run_ff <= 1'b0;
		end else if (stop_det || to_hit || !toc_ff.en) begin
			to_run_ff <= 1'b0;
		end else if (addr_hit && i2c_enable && !start_det) begin
			to_run_ff <= 1'b1;
		end
	end

	// The sub clock is divided by 32 before counting periods.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pre_ff <= '0;
			to_cnt_ff <= '0;
		end else if (!to_run_ff || scl_fall) begin
			pre_ff <= '0;
			to_cnt_ff <= '0;
		end else if (sub_rise) begin
			pre_ff <= pre_ff + 5'h01;
			if (tick) begin
				to_cnt_ff <= to_cnt_ff + 7'h01;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			line_out_ff <= 1'b0;
		end else begin
			line_out_ff <= 1'b0;
		end
	end

	assign scl_out = line_out_ff;
	assign sda_out = line_out_ff;
	assign scl_oe = stretch_ff;
	assign sda_oe = sda_oe_ff;
	assign serial_ctrl_reg1 = ctrl1_ff;
	assign serial_data_reg = data_ff;
	assign timeout_ctrl_reg = toc_ff;
	assign serial_irq_flag = irq_ff;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	timeout_sets_a:
	assert property (to_hit |=> toc_ff.flag && !toc_ff.en && !to_run_ff)
		else $error("time-out did not set flag and clear enable");
	timeout_irq_a:
	assert property (to_hit |=> irq_ff)
		else $error("time-out did not raise interrupt");
	timeout_ctrl1_a:
	assert property (to_hit |=> ctrl1_ff == CTRL1_POR && st_ff == ST_IDLE
		&& !scl_oe && !sda_oe)
		else $error("time-out did not reset interface");
	flag_hold_a:
	assert property (toc_ff.flag && !timeout_flag_clr |=> toc_ff.flag)
		else $error("time-out flag dropped without clear");
	fall_clears_a:
	assert property (scl_fall |=> to_cnt_ff == '0 && pre_ff == '0)
		else $error("clock fall did not clear time-out counter");
	stop_halts_a:
	assert property (stop_det |=> !to_run_ff ##1 !to_run_ff)
		else $error("stop did not halt time-out");
	stretch_hold_a:
	assert property (stretch_ff && !data_rd && !data_wr && !to_hit &&
		!stop_det && !start_det && i2c_enable |=> scl_oe)
		else $error("clock released without data access");
	rx_ack_drive_a:
	assert property (byte_end && !htx |=>
		sda_oe == !$past(ctrl1_ff.tx_ack_bit))
		else $error("receiver acknowledge level wrong");
	addr_ack_a:
	assert property (addr_hit && i2c_enable && !stop_det && !to_hit &&
		!start_det |=> sda_oe && st_ff == ST_ADDR_ACK)
		else $error("matching address not acknowledged");
	rx_store_a:
	assert property (byte_end && !htx |=> data_ff == $past(shift_ff))
		else $error("received byte not stored");
	nack_release_a:
	assert property (ack_end && htx && ctrl1_ff.rx_ack_bit && !to_hit &&
		!stop_det && !start_det && i2c_enable |=>
		!sda_oe && st_ff == ST_WAIT_STOP)
		else $error("data line not released on missing acknowledge");
endmodule

// File: bench/ist_master.sv
// Bus master model driving the clock and data lines of the slave.
`timescale 1ns/1ps
module ist_master (
	input wire logic clk, // Bench system clock.
	input wire logic scl_w, // Resolved clock line.
	input wire logic sda_w, // Resolved data line.
	output logic scl_drv, // Low pulls the clock line down.
	output logic sda_drv, // Low pulls the data line down.
	output logic stuck // High once a held clock never came back.
);
	initial begin
		scl_drv = 1'b1;
		sda_drv = 1'b1;
		stuck = 1'b0;
	end
	task automatic hold(input int n);
		repeat (n) @(posedge clk);
	endtask
	// Waits out clock stretching by the slave, but never for ever.
	task automatic rise;
		int i;
		scl_drv <= 1'b1;
		i = 0;
		@(posedge clk);
		while (scl_w !== 1'b1 && i < 4000) begin
			@(posedge clk);
			i++;
		end
		if (i >= 4000)
			stuck <= 1'b1;
		hold(10);
	endtask
	task automatic start;
		sda_drv <= 1'b1;
		hold(10);
		rise();
		sda_drv <= 1'b0;
		hold(10);
		scl_drv <= 1'b0;
		hold(10);
	endtask
	task automatic stop;
		sda_drv <= 1'b0;
		hold(10);
		rise();
		sda_drv <= 1'b1;
		hold(10);
	endtask
	task automatic put_bit(input logic b, output logic r);
		sda_drv <= b;
		hold(10);
		rise();
		r = sda_w;
		scl_drv <= 1'b0;
		hold(10);
	endtask
	task automatic xfer(input logic [7:0] d, input logic a,
		output logic [7:0] q, output logic k);
		for (int i = 7; i >= 0; i--)
			put_bit(d[i], q[i]);
		put_bit(a, k);
	endtask
endmodule

// File: bench/testbench.sv
// Self-checking bench for the slave data phase and bus time-out.
`timescale 1ns/1ps
module testbench;
	import ist_pkg::*;
	localparam int CW = 0, DW = 1, DR = 2, TW = 3, FC = 4, IC = 5;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic sub_clock = 1'b0;
	logic [5:0] stb = 6'h00;
	logic scl_oe, sda_oe, scl_out, sda_out, scl_drv, sda_drv, stuck, k;
	logic serial_irq_flag;
	logic ctrl1_tx_mode = 1'b0;
	logic ctrl1_tx_ack = 1'b0;
	logic [6:0] own_address_reg = 7'h00;
	logic [7:0] data_wdata = 8'h00;
	logic [7:0] serial_data_reg, q, d;
	logic [7:0] mq[$];
	ist_toc_type toc_wdata = TOC_POR;
	ist_toc_type timeout_ctrl_reg;
	ist_ctrl1_type serial_ctrl_reg1;
	wire logic scl_w = scl_drv & (scl_oe ? scl_out : 1'b1);
	wire logic sda_w = sda_drv & (sda_oe ? sda_out : 1'b1);
	int failures = 0;
	int samples_checked = 0;
	int i;
	always #10 sys_clk = ~sys_clk;
	always #80 sub_clock = ~sub_clock;
	ist_i2c_slave i_ist_i2c_slave (.sys_clk(sys_clk), .rst_n(rst_n),
		.scl_in(scl_w), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_w),
		.sda_out(sda_out), .sda_oe(sda_oe), .sub_clock(sub_clock),
		.i2c_enable(1'b1), .own_address_reg(own_address_reg),
		.ctrl1_wr(stb[CW]), .ctrl1_tx_mode(ctrl1_tx_mode),
		.ctrl1_tx_ack(ctrl1_tx_ack), .serial_ctrl_reg1(serial_ctrl_reg1),
		.data_wr(stb[DW]), .data_wdata(data_wdata), .data_rd(stb[DR]),
		.serial_data_reg(serial_data_reg), .toc_wr(stb[TW]),
		.toc_wdata(toc_wdata), .timeout_flag_clr(stb[FC]),
		.timeout_ctrl_reg(timeout_ctrl_reg), .irq_clr(stb[IC]),
		.serial_irq_flag(serial_irq_flag));
	ist_master i_ist_master (.clk(sys_clk), .scl_w(scl_w), .sda_w(sda_w),
		.scl_drv(scl_drv), .sda_drv(sda_drv), .stuck(stuck));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp,
		input string what);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t: %s got %h want %h", $time, what, got,
				exp);
		end
	endtask
	task automatic pulse(input int n);
		@(posedge sys_clk);
		stb[n] <= 1'b1;
		@(posedge sys_clk);
		stb <= 6'h00;
		@(posedge sys_clk);
	endtask
	task automatic addr(input logic [6:0] a, input logic rw);
		i_ist_master.start();
		i_ist_master.xfer({a, rw}, 1'b1, q, k);
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	always @(posedge stuck) begin
		failures++;
		$display("mismatch at %0t: clock line never released", $time);
		test_done();
	end
	initial begin
		i = $urandom(32'h0c898f4f);
		repeat (20) @(posedge sys_clk);
		chk(serial_ctrl_reg1, 8'h01, "ctrl1 reset");
		chk(timeout_ctrl_reg, 8'h00, "reset toc");
		chk(serial_data_reg, 8'h00, "reset data");
		chk({scl_oe, sda_oe, serial_irq_flag, scl_out, sda_out}, 8'h00,
			"reset outs");
		rst_n <= 1'b1;
		own_address_reg <= 7'($urandom);
		toc_wdata <= 8'h81;
		pulse(TW);
		chk(timeout_ctrl_reg, 8'h81, "toc write");
		addr(own_address_reg, 1'b0);
		chk({k, serial_irq_flag, scl_oe}, 8'h03, "addr ack");
		for (int n = 0; n < 2; n++) begin
			ctrl1_tx_ack <= n[0];
			pulse(CW);
			pulse(IC);
			pulse(DR);
			d = 8'($urandom);
			i_ist_master.xfer(d, 1'b1, q, k);
			chk(serial_data_reg, d, "rx byte");
			chk({k, serial_irq_flag, scl_oe}, {n[0], 2'b11}, "rx ack");
		end
		pulse(DR);
		i_ist_master.stop();
		repeat (800) @(posedge sys_clk);
		chk(timeout_ctrl_reg, 8'h81, "quiet");
		$display("test receive done");
		addr(own_address_reg, 1'b1);
		chk({k, serial_ctrl_reg1.read_req}, 8'h01, "read addr");
		ctrl1_tx_mode <= 1'b1;
		pulse(CW);
		for (int n = 0; n < 2; n++) begin
			d = 8'($urandom);
			mq.push_back(d);
			data_wdata <= d;
			pulse(IC);
			pulse(DW);
			i_ist_master.xfer(8'hff, n[0], q, k);
			chk(q, mq.pop_front(), "tx byte");
			chk({serial_ctrl_reg1.rx_ack_bit, serial_irq_flag}, {n[0], 1'b1},
				"rx ack bit");
		end
		repeat (20) @(posedge sys_clk);
		chk({sda_oe, scl_oe}, 8'h00, "released");
		i_ist_master.stop();
		addr(own_address_reg ^ 7'h01, 1'b0);
		chk({k, scl_oe}, 8'h02, "foreign addr");
		i_ist_master.stop();
		$display("test transmit done");
		addr(own_address_reg, 1'b0);
		pulse(IC);
		repeat (200) @(posedge sys_clk);
		chk(timeout_ctrl_reg, 8'h81, "early");
		for (i = 0; i < 1000 && timeout_ctrl_reg.flag !== 1'b1; i++)
			@(posedge sys_clk);
		if (i >= 1000) begin
			failures++;
			$display("mismatch at %0t: time-out flag never set", $time);
			test_done();
		end
		repeat (2) @(posedge sys_clk);
		chk(timeout_ctrl_reg, 8'h41, "timeout");
		chk({serial_irq_flag, scl_oe, sda_oe}, 8'h04, "to outs");
		chk(serial_ctrl_reg1, 8'h01, "to ctrl1");
		chk(serial_data_reg, d, "to data");
		repeat (600) @(posedge sys_clk);
		chk(timeout_ctrl_reg, 8'h41, "flag sticks");
		pulse(FC);
		chk(timeout_ctrl_reg, 8'h01, "flag clear");
		i_ist_master.stop();
		addr(own_address_reg, 1'b0);
		repeat (700) @(posedge sys_clk);
		chk(timeout_ctrl_reg, 8'h01, "disabled");
		chk(scl_oe, 8'h01, "still held");
		pulse(DR);
		i_ist_master.stop();
		$display("test timeout done");
		test_done();
	end
endmodule
